// *** shared/disk_fn_pkg.sv ***
package disk_fn_pkg;
  // Channel function codes, octal as issued on the function lines.
  localparam logic [3:0] CH_DEV_FN = 4'h5;
  localparam logic [3:0] CH_IE_CLR = 4'h6;
  localparam logic [3:0] CH_IE_SET = 4'h7;
  localparam logic [3:0] CH_LMA_RD = 4'h8;
  localparam logic [3:0] CH_IPC_RD = 4'h9;
  localparam logic [3:0] CH_PARAM_LD = 4'he;
  // Device function codes, octal 17, 20 through 25 and 27.
  localparam logic [7:0] DF_CMD_ONLY = 8'h0f;
  localparam logic [7:0] DF_RD_DATA = 8'h10;
  localparam logic [7:0] DF_RD_ID = 8'h11;
  localparam logic [7:0] DF_RD_ABS = 8'h12;
  localparam logic [7:0] DF_RD_ECC = 8'h13;
  localparam logic [7:0] DF_WR_DATA = 8'h14;
  localparam logic [7:0] DF_FORMAT = 8'h15;
  localparam logic [7:0] DF_WR_ECC = 8'h17;
  // Field layout of the parameter word.
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 8;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam int ID_PARCELS = 4;
  localparam int FIFO_DEPTH = 8;
  // Phase of a bus exchange driven to the spindles.
  typedef enum logic [1:0] {
    PH_NONE = 2'h0,
    PH_HEADER = 2'h1,
    PH_FIELD = 2'h3,
    PH_COMMAND = 2'h2
  } phase_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HDR = 3'h1,
    ST_HDR_WAIT = 3'h3,
    ST_FLD = 3'h2,
    ST_FLD_WAIT = 3'h6,
    ST_CMD_WAIT = 3'h4
  } state_t;
endpackage

// *** hdl/word_fifo.sv ***
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointer, count and storage values.
  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      mem <= next_mem;
    end
  end
endmodule

// *** hdl/fn_table.sv ***
`timescale 1ns/10ps
module fn_table
  import disk_fn_pkg::*;
(
  input wire logic [7:0] code,
  output logic valid,
  output logic need_hdr,
  output logic hdr_check,
  output logic hdr_write,
  output logic id_to_buf,
  output logic has_field,
  output logic field_write,
  output logic ecc_on,
  output logic cmd_only
);
  // Decode of one device function into its exchange plan.
  always_comb begin
    valid = 1'b1;
    need_hdr = 1'b0;
    hdr_check = 1'b0;
    hdr_write = 1'b0;
    id_to_buf = 1'b0;
    has_field = 1'b0;
    field_write = 1'b0;
    ecc_on = 1'b0;
    cmd_only = 1'b0;
    case (code)
      DF_CMD_ONLY: cmd_only = 1'b1;
      DF_RD_DATA: begin
        need_hdr = 1'b1;
        hdr_check = 1'b1;
        has_field = 1'b1;
        ecc_on = 1'b1;
      end
      DF_RD_ID: begin
        need_hdr = 1'b1;
        hdr_check = 1'b1;
        id_to_buf = 1'b1;
      end
      DF_RD_ABS: begin
        need_hdr = 1'b1;
        has_field = 1'b1;
        ecc_on = 1'b1;
      end
      DF_RD_ECC: begin
        need_hdr = 1'b1;
        hdr_check = 1'b1;
        has_field = 1'b1;
      end
      DF_WR_DATA: begin
        need_hdr = 1'b1;
        hdr_check = 1'b1;
        has_field = 1'b1;
        field_write = 1'b1;
        ecc_on = 1'b1;
      end
      DF_FORMAT: begin
        need_hdr = 1'b1;
        hdr_write = 1'b1;
        ecc_on = 1'b1;
      end
      DF_WR_ECC: begin
        need_hdr = 1'b1;
        hdr_check = 1'b1;
        has_field = 1'b1;
        field_write = 1'b1;
      end
      default: valid = 1'b0;
    endcase
  end
endmodule

// *** hdl/disk_channel_function_decoder.sv ***
// Functional notes
// - Function 17: command exchange, no data.
// - Header read until compare and ECC done.
// - Function 20: field read high byte, check ECC.
// - Function 21: header read, ID parcels to buffer.
// - Function 22: header without checks, field checked.
// - Function 23: field read, ECC passed along.
// - Function 24: field write after match, ECC generated.
// - Function 25: header write, ECC generated.
// - Function 27: field write, ECC from buffer.
// - Channel function 6 clears interrupt enable.
// - Channel function 7 sets interrupt enable.
// - Enable functions leave busy, done unchanged.
// - Function 10 returns local address unchanged.
// - Function 11 returns complemented parcel count.
`timescale 1ns/10ps
module disk_channel_function_decoder
  import disk_fn_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fn_strobe,
  input wire logic [3:0] fn_code,
  input wire logic [15:0] acc_in,
  output logic [15:0] acc_out,
  output logic acc_valid,
  output logic busy,
  output logic done,
  output logic int_enable,
  input wire logic int_request,
  output logic int_ack,
  input wire logic [15:0] current_local_memory_address,
  input wire logic [15:0] parcel_count,
  output logic [1:0] phase,
  output logic [7:0] bus_control,
  output logic xfer_write,
  output logic id_compare_en,
  output logic ecc_check_en,
  output logic ecc_gen_en,
  output logic ecc_to_buffer,
  output logic exch_start,
  input wire logic exch_done,
  input wire logic id_match,
  input wire logic ecc_ok,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  output logic buf_valid,
  input wire logic buf_ready,
  output logic [15:0] buf_data
);
  logic [15:0] param, next_param;
  logic [7:0] dev_code, next_dev_code;
  logic [15:0] acc_q, next_acc_q;
  logic acc_v, next_acc_v;
  logic ie, next_ie;
  logic busy_q, next_busy_q, done_q, next_done_q;
  state_t state, next_state;
  logic [2:0] id_cnt, next_id_cnt;
  logic start_q, next_start_q;
  logic tv, t_need_hdr, t_hdr_check, t_hdr_write, t_id_buf;
  logic t_field, t_fwrite, t_ecc, t_cmd;
  logic fifo_in_valid, fifo_in_ready;
  logic [15:0] fifo_in_data;
  logic dev_issue;
  logic exch_done_s1, exch_done_s2, id_match_s1, id_match_s2;
  logic ecc_ok_s1, ecc_ok_s2, irq_s1, irq_s2;

  // Drive-side and interrupt inputs come from another domain.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      exch_done_s1 <= 1'b0;
      exch_done_s2 <= 1'b0;
      id_match_s1 <= 1'b0;
      id_match_s2 <= 1'b0;
      ecc_ok_s1 <= 1'b0;
      ecc_ok_s2 <= 1'b0;
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
    end else begin
      exch_done_s1 <= exch_done;
      exch_done_s2 <= exch_done_s1;
      id_match_s1 <= id_match;
      id_match_s2 <= id_match_s1;
      ecc_ok_s1 <= ecc_ok;
      ecc_ok_s2 <= ecc_ok_s1;
      irq_s1 <= int_request;
      irq_s2 <= irq_s1;
    end
  end

  fn_table u_table (
    .code(dev_code),
    .valid(tv),
    .need_hdr(t_need_hdr),
    .hdr_check(t_hdr_check),
    .hdr_write(t_hdr_write),
    .id_to_buf(t_id_buf),
    .has_field(t_field),
    .field_write(t_fwrite),
    .ecc_on(t_ecc),
    .cmd_only(t_cmd)
  );

  // Read data toward the I/O buffer; drive data that arrives while the buffer is full is dropped.
  word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  assign dev_issue = fn_strobe && (fn_code == CH_DEV_FN) && (state == ST_IDLE);

  // Header ID parcels during a read-ID, or field data during a field read.
  always_comb begin
    fifo_in_data = rd_data;
    fifo_in_valid = 1'b0;
    if (rd_valid && state == ST_HDR_WAIT && t_id_buf && id_cnt != 3'(ID_PARCELS)) begin
      fifo_in_valid = 1'b1;
    end else if (rd_valid && state == ST_FLD_WAIT && !t_fwrite) begin
      fifo_in_valid = 1'b1;
    end
  end
  // Channel function decode and exchange sequencer, next values.
  always_comb begin
    next_param = param;
    next_dev_code = dev_code;
    next_acc_q = acc_q;
    next_acc_v = 1'b0;
    next_ie = ie;
    next_busy_q = busy_q;
    next_done_q = done_q;
    next_state = state;
    next_id_cnt = id_cnt;
    next_start_q = 1'b0;
    if (fn_strobe) begin
      case (fn_code)
        CH_PARAM_LD: next_param = acc_in;
        CH_IE_CLR: next_ie = 1'b0;
        CH_IE_SET: next_ie = 1'b1;
        CH_LMA_RD: begin
          next_acc_q = current_local_memory_address;
          next_acc_v = 1'b1;
        end
        CH_IPC_RD: begin
          next_acc_q = ~parcel_count;
          next_acc_v = 1'b1;
        end
        default: ;
      endcase
    end
    case (state)
      ST_IDLE: begin
        if (dev_issue) begin
          next_dev_code = {2'b00, acc_in[5:0]};
        end
        if (dev_issue && acc_in[15:6] == '0 && (acc_in[5:0] == DF_CMD_ONLY[5:0] ||
            acc_in[5:0] >= DF_RD_DATA[5:0] && acc_in[5:0] <= DF_WR_ECC[5:0] &&
            acc_in[5:0] != 6'h16)) begin
          next_busy_q = 1'b1;
          next_done_q = 1'b0;
          next_id_cnt = '0;
          next_state = ST_HDR;
        end
      end
      ST_HDR: begin
        next_start_q = 1'b1;
        next_state = t_cmd ? ST_CMD_WAIT : ST_HDR_WAIT;
      end
      ST_CMD_WAIT: begin
        if (exch_done_s2) begin
          next_busy_q = 1'b0;
          next_done_q = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_HDR_WAIT: begin
        if (fifo_in_valid && fifo_in_ready) begin
          next_id_cnt = id_cnt + 1'b1;
        end
        // A failed compare or ECC ends the function, busy stays up.
        if (exch_done_s2) begin
          if (t_hdr_check && !(id_match_s2 && ecc_ok_s2)) begin
            next_done_q = 1'b1;
            next_state = ST_IDLE;
          end else if (t_field) begin
            next_state = ST_FLD;
          end else begin
            next_busy_q = t_id_buf && !ecc_ok_s2;
            next_done_q = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_FLD: begin
        next_start_q = 1'b1;
        next_state = ST_FLD_WAIT;
      end
      ST_FLD_WAIT: begin
        if (exch_done_s2) begin
          next_busy_q = t_ecc && !t_fwrite && !ecc_ok_s2;
          next_done_q = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Registers only.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      param <= RESET_WORD;
      dev_code <= '0;
      acc_q <= RESET_WORD;
      acc_v <= 1'b0;
      ie <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      state <= ST_IDLE;
      id_cnt <= '0;
      start_q <= 1'b0;
    end else begin
      param <= next_param;
      dev_code <= next_dev_code;
      acc_q <= next_acc_q;
      acc_v <= next_acc_v;
      ie <= next_ie;
      busy_q <= next_busy_q;
      done_q <= next_done_q;
      state <= next_state;
      id_cnt <= next_id_cnt;
      start_q <= next_start_q;
    end
  end

  // Exchange controls follow the phase; high byte only in the field phase.
  always_comb begin
    phase = PH_NONE;
    bus_control = param[LO_LSB +: BYTE_W];
    xfer_write = 1'b0;
    id_compare_en = 1'b0;
    ecc_check_en = 1'b0;
    ecc_gen_en = 1'b0;
    ecc_to_buffer = 1'b0;
    if (state == ST_CMD_WAIT || (state == ST_HDR && t_cmd)) begin
      phase = PH_COMMAND;
    end else if (state == ST_HDR || state == ST_HDR_WAIT) begin
      phase = PH_HEADER;
      xfer_write = t_hdr_write;
      id_compare_en = t_hdr_check;
      ecc_check_en = t_hdr_check || t_id_buf;
      ecc_gen_en = t_hdr_write;
    end else if (state == ST_FLD || state == ST_FLD_WAIT) begin
      phase = PH_FIELD;
      bus_control = param[HI_LSB +: BYTE_W];
      xfer_write = t_fwrite;
      ecc_check_en = t_ecc && !t_fwrite;
      ecc_gen_en = t_ecc && t_fwrite;
      ecc_to_buffer = !t_ecc;
    end
  end

  assign exch_start = start_q;
  assign acc_out = acc_q;
  assign acc_valid = acc_v;
  assign busy = busy_q;
  assign done = done_q;
  assign int_enable = ie;
  assign int_ack = ie && irq_s2;
endmodule

// *** tb/disk_fn_monitor.sv ***
`timescale 1ns/10ps
module disk_fn_monitor
  import disk_fn_pkg::*;
(
  input wire logic mclk, rst_n, fn_strobe, acc_valid, busy, done, int_enable, int_request, int_ack,
  input wire logic xfer_write, id_compare_en, ecc_check_en, ecc_gen_en, ecc_to_buffer, exch_start,
  input wire logic [3:0] fn_code,
  input wire logic [1:0] phase,
  input wire logic [7:0] bus_control,
  input wire logic [15:0] acc_in, acc_out, current_local_memory_address, parcel_count
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [15:0] prm;
  logic [15:0] next_prm;
  logic [7:0] dev;
  logic [7:0] next_dev;
  logic dev_go;
  logic [7:0] code;
  // Shadow of the parameter word and of the accepted device code.
  always_comb begin
    code = {2'h0, acc_in[5:0]};
    dev_go = fn_strobe && fn_code == CH_DEV_FN && phase == PH_NONE;
    next_prm = (fn_strobe && fn_code == CH_PARAM_LD) ? acc_in : prm;
    next_dev = dev_go ? code : dev;
  end
  // Only registers here, so the shadow lags the strobe by one edge like the design.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prm <= 16'h0000;
      dev <= 8'h00;
    end else begin
      prm <= next_prm;
      dev <= next_dev;
    end
  end
  sequence launch;
    busy && !done ##1 exch_start;
  endsequence
  sequence quiet;
    (phase == PH_NONE && !exch_start && $stable(busy) && $stable(done)) [*3];
  endsequence
  property starts(logic [7:0] c, logic [1:0] ph);
    dev_go && code == c |=> phase == ph ##0 launch;
  endproperty
  a_cmd_launch: assert property (starts(DF_CMD_ONLY, PH_COMMAND))
    else $error("command start wrong");
  a_fmt_launch: assert property (dev_go && code == DF_FORMAT |=> phase == PH_HEADER && xfer_write && ecc_gen_en ##0 launch)
    else $error("format start wrong");
  a_ie_clear: assert property (fn_strobe && fn_code == CH_IE_CLR |=> !int_enable && !int_ack)
    else $error("enable not cleared");
  a_ie_set: assert property (fn_strobe && fn_code == CH_IE_SET |=> int_enable)
    else $error("enable not set");
  a_ack_follow: assert property ((int_enable && int_request) [*4] |-> int_ack)
    else $error("no acknowledge");
  // Only checked while idle, since a running sequence may end in the same cycle.
  a_ie_flags: assert property (fn_strobe && fn_code[3:1] == 3'h3 && !$past(fn_strobe) && phase == PH_NONE
    |=> $stable(busy) && $stable(done))
    else $error("flags moved");
  a_lma_read: assert property (fn_strobe && fn_code == CH_LMA_RD |=> acc_valid && acc_out == $past(current_local_memory_address))
    else $error("address readback");
  a_ipc_read: assert property (fn_strobe && fn_code == CH_IPC_RD |=> acc_valid && acc_out == ~$past(parcel_count))
    else $error("count readback");
  a_low_ctrl: assert property (phase == PH_HEADER || phase == PH_COMMAND |-> bus_control == prm[7:0])
    else $error("low control byte");
  a_high_ctrl: assert property (phase == PH_FIELD |-> bus_control == prm[15:8])
    else $error("high control byte");
  a_hdr_mode: assert property (phase == PH_HEADER |-> xfer_write == (dev == DF_FORMAT) &&
    ecc_check_en == (dev != DF_FORMAT && dev != DF_RD_ABS) && !(dev == DF_RD_ABS && id_compare_en))
    else $error("header mode");
  a_fld_mode: assert property (phase == PH_FIELD |-> dev != DF_RD_ID && dev != DF_FORMAT &&
    xfer_write == (dev == DF_WR_DATA || dev == DF_WR_ECC) && ecc_gen_en == (dev == DF_WR_DATA) &&
    ecc_check_en == (dev == DF_RD_DATA || dev == DF_RD_ABS) && (xfer_write || ecc_to_buffer == (dev == DF_RD_ECC)))
    else $error("field mode");
  a_undef_quiet: assert property (dev_go && code != DF_CMD_ONLY && !(code inside {[8'h10:8'h15], 8'h17}) |=> quiet)
    else $error("undefined code acted");
endmodule
bind disk_channel_function_decoder disk_fn_monitor u_mon (.mclk, .rst_n, .fn_strobe, .acc_valid, .busy, .done,
  .int_enable, .int_request, .int_ack, .xfer_write, .id_compare_en, .ecc_check_en, .ecc_gen_en, .ecc_to_buffer,
  .exch_start, .fn_code, .phase, .bus_control, .acc_in, .acc_out, .current_local_memory_address, .parcel_count);

// *** tb/spindle_model.sv ***
`timescale 1ns/10ps
module spindle_model
  import disk_fn_pkg::*;
#(
  parameter logic [15:0] HDR_BASE = 16'h0a50,
  parameter int N_HDR = 6,
  parameter int N_FLD = 12
) (
  input wire logic mclk, rst_n, exch_start, xfer_write, good, slow,
  input wire logic [1:0] phase,
  output logic exch_done, rd_valid, id_match, ecc_ok,
  output logic [15:0] rd_data
);
  logic run, reading, hdr, tgl;
  logic [1:0] hold;
  int left, cnt;
  logic [15:0] word;
  // Each read exchange streams its words; every exchange then shows done briefly; slow mode adds drive latency.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {run, reading, hdr, tgl, exch_done, rd_valid} <= 6'h00;
      hold <= 2'h0;
      left <= 0;
      cnt <= 0;
      word <= 16'h0000;
    end else begin
      tgl <= ~tgl;
      rd_valid <= 1'b0;
      if (exch_start) begin
        run <= 1'b1;
        reading <= !xfer_write && phase != PH_COMMAND;
        hdr <= phase == PH_HEADER;
        left <= (slow ? 12 : 2) + (phase == PH_HEADER ? N_HDR : N_FLD);
        cnt <= 0;
        exch_done <= 1'b0;
      end else if (run) begin
        if (reading && cnt < (hdr ? N_HDR : N_FLD)) begin
          rd_valid <= 1'b1;
          word <= (hdr ? HDR_BASE : ~HDR_BASE) + 16'(cnt);
          cnt <= cnt + 1;
        end
        left <= left - 1;
        if (left == 0) begin
          run <= 1'b0;
          exch_done <= 1'b1;
          hold <= 2'h2;
        end
      end else if (hold != 2'h0) begin
        hold <= hold - 2'h1;
        exch_done <= hold != 2'h1;
      end
    end
  end
  // Status and data lines wander outside their window, as a released bus would.
  assign id_match = exch_done ? good : tgl;
  assign ecc_ok = exch_done ? good : ~tgl;
  assign rd_data = rd_valid ? word : ~word;
endmodule

// *** tb/disk_channel_function_decoder_bench.sv ***
`timescale 1ns/10ps
module disk_channel_function_decoder_bench
  import disk_fn_pkg::*;
;
  localparam logic [15:0] HDR_BASE = 16'h0a50;
  logic mclk = 0, rst_n = 0, fn_strobe = 0, int_request = 0, buf_ready = 1, good = 1, slow = 0;
  logic [3:0] fn_code = 4'h0;
  logic [15:0] acc_in = 16'h0000, current_local_memory_address = 16'h0000, parcel_count = 16'h0000;
  logic [15:0] acc_out, rd_data, buf_data;
  logic [1:0] phase;
  logic [7:0] bus_control;
  logic acc_valid, busy, done, int_enable, int_ack, xfer_write, id_compare_en, ecc_check_en, ecc_gen_en;
  logic ecc_to_buffer, exch_start, exch_done, id_match, ecc_ok, rd_valid, buf_valid;
  int starts, cyc, bad_count, samples_checked, seed;
  logic [15:0] q[$];
  logic [7:0] codes [8] = '{DF_CMD_ONLY, DF_RD_DATA, DF_RD_ID, DF_RD_ABS, DF_RD_ECC, DF_WR_DATA, DF_FORMAT, DF_WR_ECC};
  disk_channel_function_decoder u_dut (.mclk, .rst_n, .fn_strobe, .fn_code, .acc_in, .acc_out, .acc_valid,
    .busy, .done, .int_enable, .int_request, .int_ack, .current_local_memory_address, .parcel_count, .phase,
    .bus_control, .xfer_write, .id_compare_en, .ecc_check_en, .ecc_gen_en, .ecc_to_buffer, .exch_start,
    .exch_done, .id_match, .ecc_ok, .rd_valid, .rd_data, .buf_valid, .buf_ready, .buf_data);
  spindle_model #(.HDR_BASE(HDR_BASE)) u_far (.mclk, .rst_n, .exch_start, .xfer_write, .good, .slow, .phase,
    .exch_done, .rd_valid, .id_match, .ecc_ok, .rd_data);
  always #20 mclk = ~mclk;
  // Count exchanges, collect drained buffer words and cut a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (exch_start === 1'b1) starts++;
    if (buf_valid === 1'b1 && buf_ready) q.push_back(buf_data);
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [3:0] c, input logic [15:0] a);
    @(posedge mclk) #1;
    fn_strobe = 1'b1;
    fn_code = c;
    acc_in = a;
    @(posedge mclk) #1;
    fn_strobe = 1'b0;
  endtask
  // Launch a device function and wait, bounded, for done.
  task automatic run(input logic [7:0] c);
    starts = 0;
    q.delete();
    slow = 1'($random(seed));
    issue(CH_DEV_FN, {8'h00, c});
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge mclk) #1;
    @(posedge mclk) #1;
  endtask
  function automatic logic [15:0] exp_starts(input logic [7:0] c);
    return (c == DF_CMD_ONLY || c == DF_RD_ID || c == DF_FORMAT) ? 16'h0001 : 16'h0002;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence: error path first, then every defined code, refusals, readbacks, buffer.
  initial begin
    seed = 32'h007eadc4;
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk({12'h000, busy, done, int_enable, acc_valid}, 16'h0000);
    $display("test reset done");
    issue(CH_PARAM_LD, 16'($random(seed)));
    good = 1'b0;
    run(DF_RD_DATA);
    chk({14'h0, busy, done}, 16'h0003);
    chk(16'(starts), 16'h0001);
    // Unchecked header passes despite bad status; the field ECC error keeps busy up.
    run(DF_RD_ABS);
    chk({14'h0, busy, done}, 16'h0003);
    chk(16'(starts), 16'h0002);
    good = 1'b1;
    issue(CH_IE_SET, 16'h0000);
    chk({15'h0, int_enable}, 16'h0001);
    int_request = 1'b1;
    repeat (5) @(posedge mclk);
    chk({15'h0, int_ack}, 16'h0001);
    issue(CH_IE_CLR, 16'h0000);
    chk({14'h0, int_enable, int_ack}, 16'h0000);
    chk({14'h0, busy, done}, 16'h0003);
    int_request = 1'b0;
    $display("test mismatch and enable done");
    foreach (codes[k]) begin
      run(codes[k]);
      chk({14'h0, busy, done}, 16'h0001);
      chk(16'(starts), exp_starts(codes[k]));
      if (codes[k] == DF_RD_ID) begin
        chk(16'(q.size()), 16'h0004);
        for (int i = 0; i < 4; i++) chk(q[i], HDR_BASE + 16'(i));
      end
    end
    $display("test device functions done");
    foreach (codes[k]) begin
      starts = 0;
      issue(CH_DEV_FN, k == 0 ? 16'h0016 : k == 1 ? 16'h000e : 16'h0018 + 16'($random(seed) & 8'h1f));
      repeat (10) @(posedge mclk);
      chk({14'h0, busy, done}, 16'h0001);
      chk(16'(starts), 16'h0000);
    end
    $display("test undefined codes done");
    for (int k = 0; k < 6; k++) begin
      current_local_memory_address = k == 0 ? 16'hffff : 16'($random(seed));
      parcel_count = k == 0 ? 16'h0000 : 16'($random(seed));
      issue(CH_LMA_RD, 16'($random(seed)));
      chk({15'h0, acc_valid}, 16'h0001);
      chk(acc_out, current_local_memory_address);
      issue(CH_IPC_RD, 16'($random(seed)));
      chk(acc_out, ~parcel_count);
      chk(16'hffff - acc_out, parcel_count);
    end
    $display("test readback done");
    buf_ready = 1'b0;
    run(DF_RD_ECC);
    chk({14'h0, busy, done}, 16'h0001);
    buf_ready = 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    chk(16'(q.size()), 16'h0008);
    for (int i = 0; i < 8; i++) chk(q[i], ~HDR_BASE + 16'(i));
    chk({15'h0, buf_valid}, 16'h0000);
    $display("test buffer done");
    wrap_up();
  end
endmodule
